// ==== common/mode_lock_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the mode-gated register bank
`ifndef MODE_LOCK_DEFINES_SVH
`define MODE_LOCK_DEFINES_SVH

`define ML_ADR_MODE_CTRL 8'h00
`define ML_ADR_STATUS 8'h04
`define ML_ADR_SS_EN 8'h08
`define ML_ADR_OE_CTRL 8'h0c
`define ML_ADR_IN_SEL 8'h10
`define ML_ADR_CFG_BASE 8'h20
`define ML_CFG_WORDS 8

`define ML_MODE_ACTIVE_BIT 0
`define ML_MODE_RESET_BIT 1
`define ML_STAT_ACTIVE_BIT 0
`define ML_STAT_READY_BIT 1

`define ML_RST_MODE_ACTIVE 1'b0
`define ML_RST_SS_EN 1'b0
`define ML_RST_OE 8'hff
`define ML_RST_IN_SEL 2'h0
`define ML_RST_CFG 32'h0000_0000

`define ML_SOFT_RESET_NS 16
`define ML_CLK_PERIOD_NS 4
`define ML_SOFT_RESET_CYC ((`ML_SOFT_RESET_NS + `ML_CLK_PERIOD_NS - 1) / `ML_CLK_PERIOD_NS)

`endif

// ==== common/mode_lock_pkg.sv ====
// Types shared by the mode-gated register bank
package mode_lock_pkg;

   typedef enum logic [0:0] {
      MODE_READY = 1'b0,
      MODE_ACTIVE = 1'b1
   } op_mode_type;

   typedef struct packed {
      logic [7:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
      logic cyc;
      logic stb;
   } wb_req_type;

   typedef struct packed {
      logic [31:0] dat;
      logic ack;
   } wb_rsp_type;

endpackage

// ==== rtl/mode_lock_regs.sv ====
// Mode-gated configuration register bank with Wishbone slave and output gating
`timescale 1ns/1ns
`default_nettype none
`include "mode_lock_defines.svh"

// Notes on behaviour
// [R1] Output clock enables are driven only while the mode is Active.
// [R2] In Active mode writes to locked configuration words are dropped and the words keep their values.
// [R3] In Ready mode writes to the locked configuration words are stored.
// [R4] Entering Ready stops all outputs and they stay stopped while Ready lasts.
// [R5] Going back to Active restarts outputs with the words written during Ready.
// [R6] Spread-spectrum enable, output enables, input select and mode control are writable in both modes.
// [R7] The host must not rely on Active mode to shield the exempt registers from stray writes.
// [R8] The host changes locked words by selecting Ready, writing, then selecting Active.
// [R9] A status register reports the present mode as Active or Ready.
// [R10] Writing the reset bit of the mode control register resets the whole bank.
// [R11] A blocked write is acknowledged normally, with no error indication.
module mode_lock_regs
   import mode_lock_pkg::*;
#(
   parameter int OUT_COUNT = 8,
   parameter int CFG_WORDS = `ML_CFG_WORDS
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [OUT_COUNT-1:0] out_clk_en,
   output logic ss_enable,
   output logic [1:0] in_clk_sel,
   output logic [CFG_WORDS*32-1:0] cfg_words,
   output logic mode_active
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      op_mode_type mode;
      logic ss_en;
      logic [OUT_COUNT-1:0] oe;
      logic [1:0] in_sel;
      logic [CFG_WORDS-1:0][31:0] cfg;
      logic [31:0] rdat;
      logic ack;
      logic [3:0] srst_cnt;
      logic [OUT_COUNT-1:0] out_en;
   } state_type;

   state_type s_q;
   state_type s_d;
   wb_req_type req;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic int cfg_index(input logic [7:0] adr);
      return int'(adr - `ML_ADR_CFG_BASE) >> 2;
   endfunction

   function automatic logic is_cfg(input logic [7:0] adr);
      return adr >= `ML_ADR_CFG_BASE && adr < 8'(`ML_ADR_CFG_BASE + 4 * CFG_WORDS) && adr[1:0] == 2'b00;
   endfunction

   assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i, cyc: wb_cyc_i, stb: wb_stb_i};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic take;
      logic [31:0] w;
      take = 1'b0;
      w = 32'h0000_0000;
      s_d = s_q;
      s_d.ack = 1'b0;
      take = req.cyc && req.stb && !s_q.ack;
      if (s_q.srst_cnt != 4'h0) begin
         s_d.srst_cnt = s_q.srst_cnt - 4'h1;
      end
      if (take) begin
         s_d.ack = 1'b1; // [R11]
         s_d.rdat = 32'h0000_0000;
         if (req.we) begin
            if (req.adr == `ML_ADR_MODE_CTRL) begin
               w = merge({31'h0, s_q.mode == MODE_ACTIVE}, req.dat, req.sel);
               s_d.mode = w[`ML_MODE_ACTIVE_BIT] ? MODE_ACTIVE : MODE_READY; // [R6] [R8]
               if (w[`ML_MODE_RESET_BIT]) begin
                  s_d.srst_cnt = 4'(`ML_SOFT_RESET_CYC); // [R10]
               end
            end else if (req.adr == `ML_ADR_SS_EN) begin
               w = merge({31'h0, s_q.ss_en}, req.dat, req.sel);
               s_d.ss_en = w[0]; // [R6]
            end else if (req.adr == `ML_ADR_OE_CTRL) begin
               w = merge(32'(s_q.oe), req.dat, req.sel);
               s_d.oe = w[OUT_COUNT-1:0]; // [R6]
            end else if (req.adr == `ML_ADR_IN_SEL) begin
               w = merge({30'h0, s_q.in_sel}, req.dat, req.sel);
               s_d.in_sel = w[1:0]; // [R6]
            end else if (is_cfg(req.adr) && s_q.mode == MODE_READY) begin
               // Locked word: stored in Ready only, else the ack still goes out
               s_d.cfg[cfg_index(req.adr)] = merge(s_q.cfg[cfg_index(req.adr)], req.dat, req.sel); // [R2] [R3]
            end
         end else begin
            case (1'b1)
               req.adr == `ML_ADR_MODE_CTRL: s_d.rdat = {31'h0, s_q.mode == MODE_ACTIVE};
               req.adr == `ML_ADR_STATUS: begin
                  s_d.rdat[`ML_STAT_ACTIVE_BIT] = s_q.mode == MODE_ACTIVE; // [R9]
                  s_d.rdat[`ML_STAT_READY_BIT] = s_q.mode == MODE_READY; // [R9]
               end
               req.adr == `ML_ADR_SS_EN: s_d.rdat = {31'h0, s_q.ss_en};
               req.adr == `ML_ADR_OE_CTRL: s_d.rdat = 32'(s_q.oe);
               req.adr == `ML_ADR_IN_SEL: s_d.rdat = {30'h0, s_q.in_sel};
               is_cfg(req.adr): s_d.rdat = s_q.cfg[cfg_index(req.adr)];
               default: s_d.rdat = 32'h0000_0000;
            endcase
         end
      end
      // Outputs are registered from the next mode so they change in the same cycle as the mode and never glitch on a write
      s_d.out_en = (s_d.mode == MODE_ACTIVE) ? s_d.oe : '0; // [R1] [R4] [R5]
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst || (s_q.srst_cnt == 4'h1)) begin
         // Soft reset waits ML_SOFT_RESET_CYC cycles after the ack so the writing master still sees its answer
         s_q.mode <= `ML_RST_MODE_ACTIVE ? MODE_ACTIVE : MODE_READY;
         s_q.ss_en <= `ML_RST_SS_EN;
         s_q.oe <= OUT_COUNT'(`ML_RST_OE);
         s_q.in_sel <= `ML_RST_IN_SEL;
         for (int i = 0; i < CFG_WORDS; i++) begin
            s_q.cfg[i] <= `ML_RST_CFG;
         end
         s_q.rdat <= 32'h0000_0000;
         s_q.ack <= 1'b0;
         s_q.srst_cnt <= 4'h0;
         s_q.out_en <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.rdat;
   assign out_clk_en = s_q.out_en;
   assign ss_enable = s_q.ss_en;
   assign in_clk_sel = s_q.in_sel;
   assign cfg_words = s_q.cfg;
   assign mode_active = s_q.mode == MODE_ACTIVE;

endmodule
`default_nettype wire

// ==== tb/mode_lock_regs_asserts.sv ====
// Port checker for the mode-gated register bank
`timescale 1ns/1ns
`default_nettype none
module mode_lock_asserts #(
   parameter int OUT_COUNT = 8,
   parameter int CFG_WORDS = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [OUT_COUNT-1:0] out_clk_en,
   input wire logic [CFG_WORDS*32-1:0] cfg_words,
   input wire logic mode_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic tk;
   logic wr;
   assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = tk && wb_we_i;
   a_ack_next: assert property (tk |=> wb_ack_o) else $error("no ack");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   a_out_gate: assert property (!mode_active |-> out_clk_en == '0) else $error("out on");
   a_mode_write: assert property (wr && wb_adr_i == 8'h00 |=> ($past(wb_dat_i) & 32'h1) == {31'h0, mode_active})
      else $error("mode");
   a_lock_hold: assert property (mode_active && wr && wb_adr_i[7:5] == 3'h1 |=> $stable(cfg_words))
      else $error("lock");
   a_ready_store: assert property (!mode_active && wr && wb_adr_i == 8'h20 |=> cfg_words[31:0] == $past(wb_dat_i))
      else $error("store");
   a_status_mode: assert property (tk && !wb_we_i && wb_adr_i == 8'h04 |=> wb_dat_o == {30'h0, !mode_active, mode_active})
      else $error("status");
   a_soft_reset: assert property (wr && wb_adr_i == 8'h00 && wb_dat_i[1] |-> ##[2:7] (!mode_active && cfg_words == '0))
      else $error("soft");
   c_blocked: cover property (mode_active && wr && wb_adr_i == 8'h20);
   c_run: cover property ($rose(mode_active));
   c_soft: cover property (wr && wb_dat_i[1]);
endmodule
bind mode_lock_regs mode_lock_asserts #(.OUT_COUNT(OUT_COUNT), .CFG_WORDS(CFG_WORDS)) u_chk (.sys_clk(sys_clk),
   .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .out_clk_en(out_clk_en), .cfg_words(cfg_words), .mode_active(mode_active));
`default_nettype wire

// ==== tb/wb_host_model.sv ====
// Wishbone host model that programs the register bank
`timescale 1ns/1ns
`default_nettype none
module wb_host_model
   import mode_lock_pkg::*;
(
   input wire logic sys_clk,
   output var wb_req_type req,
   input wire logic ack,
   input wire logic [31:0] rdat
);
   initial req = '0;
   // Released lines show inverted values so stale data never looks valid
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      req <= '{a, d, 4'hf, w, 1'b1, 1'b1};
      @(posedge sys_clk);
      while (ack !== 1'b1) @(posedge sys_clk);
      q = rdat;
      req <= '{~a, ~d, 4'h0, ~w, 1'b0, 1'b0};
      @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// ==== tb/mode_lock_regs_bench.sv ====
// Directed bench for the mode-gated register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s %h %h", n, e, g); end end
module mode_lock_regs_bench
   import mode_lock_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   wb_req_type req;
   logic [31:0] rdat, q;
   logic ack, ss, act;
   logic [1:0] isel;
   logic [7:0] oen;
   logic [255:0] cfg;
   int error_cnt = 0;
   int num_checks = 0;
   // {write, address, write data or expected read}
   logic [40:0] rows [11] = '{{1'b0, 8'h04, 32'h2}, {1'b1, 8'h20, 32'h1234abcd}, {1'b1, 8'h0c, 32'hf},
      {1'b1, 8'h00, 32'h1}, {1'b0, 8'h04, 32'h1}, {1'b1, 8'h20, 32'h5a5a5a5a}, {1'b0, 8'h20, 32'h1234abcd},
      {1'b1, 8'h08, 32'h1}, {1'b0, 8'h08, 32'h1}, {1'b1, 8'h10, 32'h2}, {1'b0, 8'h80, 32'h0}};
   wb_host_model u_host (.sys_clk(sys_clk), .req(req), .ack(ack), .rdat(rdat));
   mode_lock_regs u_dut (.sys_clk(sys_clk), .rst(rst), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_sel_i(req.sel),
      .wb_we_i(req.we), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_dat_o(rdat), .wb_ack_o(ack),
      .out_clk_en(oen), .ss_enable(ss), .in_clk_sel(isel), .cfg_words(cfg), .mode_active(act));
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic finish_test;
      if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ----------------
   // Main sequence
   // ----------------
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      `CHK("rst", 9'h0, {act, oen})
      foreach (rows[i]) begin
         u_host.xfer(rows[i][40], rows[i][39:32], rows[i][31:0], q);
         if (!rows[i][40]) `CHK("rd", rows[i][31:0], q)
      end
      `CHK("oe", 8'h0f, oen)
      `CHK("sel", 3'h6, {ss, isel})
      u_host.xfer(1'b1, 8'h00, 32'h0, q);
      `CHK("stop", 8'h00, oen)
      u_host.xfer(1'b1, 8'h00, 32'h3, q);
      repeat (8) @(posedge sys_clk);
      `CHK("soft", 257'h0, {act, cfg})
      finish_test;
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      error_cnt++;
      finish_test;
   end
endmodule
`default_nettype wire
